// *** include/rbq_pkg.sv ***
// Purpose: shared constants and carriers for the receive buffer queue dma
// Assumes: 50 MHz single clock, byte-wide data paths
// Notes:   status values are octal as the host sees them
package rbq_pkg;
    localparam int          RBQ_DEPTH      = 16;
    localparam int          RBQ_ADDR_W     = 24;
    localparam int          RBQ_CNT_W      = 16;
    localparam int          RBQ_LEN_W      = 11;
    localparam logic [7:0]  RBQ_ST_CMD     = 8'h80;   // octal 200
    localparam logic [7:0]  RBQ_ST_RCV     = 8'h20;   // octal 40
    localparam logic [7:0]  RBQ_ST_ERR     = 8'h01;
    localparam logic [10:0] RBQ_TX_MIN     = 11'h008;
    localparam logic [10:0] RBQ_TX_MAX     = 11'h5E4; // 1508 bytes
    localparam logic [10:0] RBQ_MIN_BODY   = 11'h03C; // 60 bytes
    localparam logic [10:0] RBQ_HDR_LEN    = 11'h004;
    localparam logic [10:0] RBQ_ADDR_LEN   = 11'h006;
    localparam logic [10:0] RBQ_FCS_LEN    = 11'h004;
    localparam logic [2:0]  RBQ_OCTAL_MASK = 3'h7;
    localparam logic [2:0]  RBQ_DUMP_LAST  = 3'h4;

    typedef enum logic [1:0] {
        RBQ_CMD_SUPPLY,
        RBQ_CMD_FLUSH,
        RBQ_CMD_DUMP,
        RBQ_CMD_SEND
    } rbq_cmd_t;

    typedef struct packed {
        logic [RBQ_ADDR_W-1:0] addr;
        logic [RBQ_CNT_W-1:0]  count;
    } rbq_buf_t;

    typedef struct packed {
        logic [RBQ_ADDR_W-1:0] addr;
        logic [7:0]            data;
    } rbq_wr_t;
endpackage

// *** src/rbq_dma.sv ***
// Purpose: receive buffer queue and frame store engine
// Assumes: host writes one byte per accepted cycle; frame bytes come
//          from the transmit path (loopback) as a byte stream whose
//          source slot is taken from the stream and overwritten
// Notes:   no software registers; commands come on a strobe port
//
// How it works
// - long frames continue into next queued buffer
// - stored frame: status, size, dest, source, payload
// - four check bytes appended after payload
// - queue holds sixteen buffer entries
// - dump gives address lo/mid/hi, count lo/hi
// - no buffers: frame dropped, no receive-done
// - flush empties queue, reports command-done
// - command-done 200, receive-done 40 octal
// - failed command: command-done plus error bit
// - transmit of 0 or 7 bytes rejected
// - transmit of 1600 bytes rejected
// - non-octal buffer: excess dropped, no chaining
// - 56-byte body fills 68-byte stored frame
// - short frames zero-padded before check bytes
// - odd and even lengths delivered unaltered
// - own station address inserted as source
// - dump returns every queued buffer (up to sixteen) in supply order
`timescale 1ns/10ps
`default_nettype none
module rbq_dma
    import rbq_pkg::*;
#(
    parameter int DEPTH = RBQ_DEPTH
)(
    input  wire logic                  i_clock,
    input  wire logic                  i_srst,
    input  wire logic                  i_cmd_valid,
    input  wire rbq_cmd_t              i_cmd,
    input  wire rbq_buf_t              i_cmd_buf,
    input  wire logic [RBQ_LEN_W-1:0]  i_tx_len,
    input  wire logic [47:0]           i_station,
    input  wire logic                  i_tx_valid,
    input  wire logic [7:0]            i_tx_data,
    output logic                       o_tx_ready,
    input  wire logic [31:0]           i_fcs,
    input  wire logic                  i_status_clear,
    output logic [7:0]                 o_status,
    output logic                       o_busy,
    output var rbq_wr_t                o_wr,
    output logic                       o_wr_valid,
    output logic [7:0]                 o_dump_data,
    output logic                       o_dump_valid
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_DUMP, ST_FRAME, ST_DONE
    } rbq_state_t;

    localparam int PW = $clog2(DEPTH);

    rbq_buf_t              queue [DEPTH];
    logic [PW-1:0]         head;
    logic [PW-1:0]         tail;
    logic [PW:0]           fill;
    rbq_state_t            state;
    logic [PW:0]           dump_idx;
    logic [2:0]            dump_byte;
    logic [10:0]           pos;       // stored-frame byte position
    logic [10:0]           size;      // frame size incl. pad and check
    logic [10:0]           body_len;
    logic [RBQ_ADDR_W-1:0] wptr;
    logic [RBQ_CNT_W-1:0]  wleft;
    logic                  dropping;
    logic                  have_buf;

    function automatic logic [7:0] byte_of(input logic [47:0] v,
                                           input logic [10:0] i);
        byte_of = v[8'(i) * 8 +: 8];
    endfunction

    wire q_empty   = (fill == '0);
    wire q_full    = (fill == (PW+1)'(DEPTH));
    wire take_cmd  = i_cmd_valid && (state == ST_IDLE);
    wire is_supply = take_cmd && (i_cmd == RBQ_CMD_SUPPLY);
    wire is_flush  = take_cmd && (i_cmd == RBQ_CMD_FLUSH);
    wire is_send   = take_cmd && (i_cmd == RBQ_CMD_SEND);
    wire is_dump   = take_cmd && (i_cmd == RBQ_CMD_DUMP);
    wire tx_bad    = (i_tx_len < RBQ_TX_MIN) || (i_tx_len > RBQ_TX_MAX);
    wire supply_ok = is_supply && !q_full;
    wire send_ok   = is_send && !tx_bad;
    // the source slot is overwritten, so the stored body is as long as
    // the transmit buffer; short bodies grow to the minimum with zeros
    wire [10:0] next_body = (i_tx_len < RBQ_MIN_BODY) ?
                            RBQ_MIN_BODY : i_tx_len;
    wire [10:0] hdr_end  = RBQ_HDR_LEN + RBQ_ADDR_LEN;
    wire [10:0] src_end  = hdr_end + RBQ_ADDR_LEN;
    wire [10:0] body_end = RBQ_HDR_LEN + body_len;
    wire [10:0] data_end = RBQ_HDR_LEN + i_tx_len;
    wire in_frame   = (state == ST_FRAME);
    wire need_tx    = in_frame && (pos >= RBQ_HDR_LEN) && (pos < data_end);
    wire step       = in_frame && (!need_tx || i_tx_valid);
    wire last_byte  = (pos == size - 11'h001);
    wire buf_end    = (wleft == 16'h0001);
    wire octal_buf  = (queue[head].count[2:0] & RBQ_OCTAL_MASK) == 3'h0;

    assign o_tx_ready = need_tx;
    assign o_busy     = (state != ST_IDLE);

    // source: dest bytes come from host, then own address, then payload
    logic [7:0] frame_byte;
    always_comb
    begin
        if (pos < 11'h002)
            frame_byte = 8'h00;
        else if (pos < RBQ_HDR_LEN)
            frame_byte = (pos[0]) ? {5'h00, size[10:8]} : size[7:0];
        else if (pos < hdr_end)
            frame_byte = i_tx_data;
        else if (pos < src_end)
            frame_byte = byte_of(i_station, pos - hdr_end);
        else if (pos < data_end)
            frame_byte = i_tx_data;
        else if (pos < body_end)
            frame_byte = 8'h00;
        else
            frame_byte = i_fcs[8'(pos - body_end) * 8 +: 8];
    end

    always_ff @(posedge i_clock)
    begin
        if (supply_ok)
            queue[tail] <= i_cmd_buf;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst || is_flush)
        begin
            head <= '0;
            tail <= '0;
            fill <= '0;
        end
        else
        begin
            if (supply_ok)
                tail <= tail + 1'b1;
            if (step && (buf_end || last_byte) && have_buf && !dropping)
            begin
                head <= head + 1'b1;
                fill <= fill - (supply_ok ? 1'b0 : 1'b1);
            end
            else if (supply_ok)
                fill <= fill + 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            state        <= ST_IDLE;
            o_status     <= 8'h00;
            pos          <= '0;
            size         <= '0;
            body_len     <= '0;
            wptr         <= '0;
            wleft        <= '0;
            dropping     <= 1'b0;
            have_buf     <= 1'b0;
            dump_idx     <= '0;
            dump_byte    <= '0;
            o_wr         <= '0;
            o_wr_valid   <= 1'b0;
            o_dump_data  <= 8'h00;
            o_dump_valid <= 1'b0;
        end
        else
        begin
            o_wr_valid   <= 1'b0;
            o_dump_valid <= 1'b0;
            if (i_status_clear)
                o_status <= 8'h00;
            case (state)
                ST_IDLE:
                begin
                    if (is_supply || is_flush)
                        o_status <= RBQ_ST_CMD | (supply_ok || is_flush ?
                                    8'h00 : RBQ_ST_ERR);
                    else if (is_send && tx_bad)
                        o_status <= RBQ_ST_CMD | RBQ_ST_ERR;
                    else if (is_dump)
                    begin
                        dump_idx  <= '0;
                        dump_byte <= '0;
                        state     <= q_empty ? ST_DONE : ST_DUMP;
                    end
                    else if (send_ok)
                    begin
                        body_len <= next_body;
                        size     <= RBQ_HDR_LEN + next_body + RBQ_FCS_LEN;
                        pos      <= '0;
                        have_buf <= !q_empty;
                        dropping <= 1'b0;
                        wptr     <= queue[head].addr;
                        wleft    <= queue[head].count;
                        state    <= ST_FRAME;
                    end
                end
                ST_DUMP:
                begin
                    o_dump_valid <= 1'b1;
                    o_dump_data  <= (dump_byte < 3'h3) ?
                        queue[head + PW'(dump_idx)].addr[8'(dump_byte)*8 +: 8] :
                        queue[head + PW'(dump_idx)].count[8'(dump_byte - 3'h3)*8 +: 8];
                    dump_byte <= (dump_byte == RBQ_DUMP_LAST) ? 3'h0
                                 : dump_byte + 3'h1;
                    if (dump_byte == RBQ_DUMP_LAST)
                    begin
                        dump_idx <= dump_idx + 1'b1;
                        if (dump_idx + 1'b1 == fill)
                            state <= ST_DONE;
                    end
                end
                ST_FRAME:
                begin
                    if (step)
                    begin
                        pos <= pos + 11'h001;
                        if (have_buf && !dropping)
                        begin
                            o_wr_valid <= 1'b1;
                            o_wr.addr  <= wptr;
                            o_wr.data  <= frame_byte;
                            wptr       <= wptr + 1'b1;
                            wleft      <= wleft - 1'b1;
                            if (buf_end && !last_byte)
                            begin
                                if (!octal_buf || fill == 1)
                                    dropping <= 1'b1;
                                else
                                begin
                                    wptr  <= queue[head + 1'b1].addr;
                                    wleft <= queue[head + 1'b1].count;
                                end
                            end
                        end
                        if (last_byte)
                        begin
                            state    <= ST_IDLE;
                            o_status <= RBQ_ST_CMD |
                                        (have_buf ? RBQ_ST_RCV : 8'h00);
                        end
                    end
                end
                ST_DONE:
                begin
                    o_status <= RBQ_ST_CMD;
                    state    <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    a_reject_short: assert property (@(posedge i_clock) disable iff (i_srst)
        (is_send && i_tx_len < RBQ_TX_MIN) |=> (o_status == 8'h81) && !o_busy)
        else $error("short transmit not rejected");
    a_reject_long: assert property (@(posedge i_clock) disable iff (i_srst)
        (is_send && i_tx_len > RBQ_TX_MAX) |=> o_status[0] && !o_busy)
        else $error("long transmit not rejected");
    a_no_store_empty: assert property (@(posedge i_clock) disable iff (i_srst)
        (in_frame && !have_buf && step && last_byte) |=>
        !o_wr_valid && ((o_status & RBQ_ST_RCV) == 8'h00))
        else $error("frame stored with empty queue");
    a_flush_clears: assert property (@(posedge i_clock) disable iff (i_srst)
        is_flush |=> (fill == '0) && (o_status == RBQ_ST_CMD))
        else $error("flush did not empty queue");
    a_queue_bound: assert property (@(posedge i_clock) disable iff (i_srst)
        fill <= (PW+1)'(DEPTH))
        else $error("queue overfilled");
    a_supply_done: assert property (@(posedge i_clock) disable iff (i_srst)
        supply_ok |=> o_status == RBQ_ST_CMD && $past(fill) + 1'b1 == fill)
        else $error("supply not acknowledged");
    a_full_error: assert property (@(posedge i_clock) disable iff (i_srst)
        (is_supply && q_full) |=> o_status == 8'h81)
        else $error("full queue supply not flagged");
    a_status_hdr: assert property (@(posedge i_clock) disable iff (i_srst)
        (step && have_buf && !dropping && pos < 11'h002) |=> o_wr.data == 8'h00)
        else $error("status word not zero");
    a_recv_done: assert property (@(posedge i_clock) disable iff (i_srst)
        (in_frame && step && last_byte && have_buf) |=> o_status == 8'hA0)
        else $error("receive done not reported");
    a_dump_len: assert property (@(posedge i_clock) disable iff (i_srst)
        (o_dump_valid && !$past(o_dump_valid)) |-> o_dump_valid [*5])
        else $error("dump record short");

    c_chain: cover property (@(posedge i_clock) step && buf_end && !last_byte && !dropping);
    c_drop: cover property (@(posedge i_clock) dropping);
    c_dump: cover property (@(posedge i_clock) state == ST_DUMP && q_full);
    c_pad: cover property (@(posedge i_clock) in_frame && pos == body_end);
endmodule // rbq_dma
`default_nettype wire

// *** tb/rbq_host_model.sv ***
// Purpose: host side of the dma: transmit byte source, memory write sink
// Assumes: a byte once offered is held until the dma takes it
// Notes:   slow mode leaves a gap after every taken byte
`timescale 1ns/10ps
`default_nettype none
module rbq_host_model
    import rbq_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    input  wire logic        i_start,
    input  wire logic        i_slow,
    input  wire logic [15:0] i_len,
    input  wire logic        i_tx_ready,
    output logic             o_tx_valid,
    output logic [7:0]       o_tx_data,
    input  wire rbq_wr_t     i_wr,
    input  wire logic        i_wr_valid
);
    logic [15:0]           idx;
    logic [RBQ_ADDR_W-1:0] wa[$];
    logic [7:0]            wd[$];
    wire  [7:0]            byte_now = 8'(idx * 7 + 3);

    // idle data inverted so a stale sample never passes as good data
    assign o_tx_data = o_tx_valid ? byte_now : ~byte_now;

    always_ff @(posedge i_clock)
    begin
        if (i_srst || i_start)
        begin
            idx        <= '0;
            o_tx_valid <= 1'b0;
        end
        else if (o_tx_valid && i_tx_ready)
        begin
            idx        <= idx + 16'h0001;
            o_tx_valid <= !i_slow && (idx + 16'h0001 < i_len);
        end
        else
            o_tx_valid <= idx < i_len;
    end

    always @(posedge i_clock)
    begin
        if (i_wr_valid === 1'b1)
        begin
            wa.push_back(i_wr.addr);
            wd.push_back(i_wr.data);
        end
    end
endmodule // rbq_host_model
`default_nettype wire

// *** tb/rbq_dma_tb.sv ***
// Purpose: self-checking bench for the receive buffer queue dma
// Assumes: host model feeds transmit bytes and records memory writes
// Notes:   complete stored frames are checked byte by byte and address by address
`timescale 1ns/10ps
`default_nettype none
module rbq_dma_tb
    import rbq_pkg::*;
;
    localparam logic [47:0] STATION = 48'hA1B2_C3D4_E5F6;
    localparam logic [31:0] FCS     = 32'h1234_5678;
    logic         i_clock      = 1'b0;
    logic         i_srst       = 1'b1;
    logic         cmd_valid    = 1'b0;
    logic         status_clear = 1'b0;
    logic         start        = 1'b0;
    logic         slow         = 1'b0;
    rbq_cmd_t     cmd          = RBQ_CMD_FLUSH;
    rbq_buf_t     cbuf         = '0;
    logic [15:0]  len          = 16'h0000;
    wire          tx_ready, tx_valid, busy, wr_valid, dump_valid;
    wire [7:0]    tx_data, status, dump_data;
    wire rbq_wr_t wr;
    int           err_total    = 0;
    int           num_checks   = 0;
    logic [7:0]   dq[$];

    always #10 i_clock = ~i_clock;

    rbq_dma rbq_dma_inst (
        .i_clock(i_clock), .i_srst(i_srst), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_cmd_buf(cbuf), .i_tx_len(len[10:0]),
        .i_station(STATION), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_ready(tx_ready), .i_fcs(FCS), .i_status_clear(status_clear),
        .o_status(status), .o_busy(busy), .o_wr(wr), .o_wr_valid(wr_valid),
        .o_dump_data(dump_data), .o_dump_valid(dump_valid));

    rbq_host_model rbq_host_model_inst (
        .i_clock(i_clock), .i_srst(i_srst), .i_start(start), .i_slow(slow),
        .i_len(len), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .i_wr(wr), .i_wr_valid(wr_valid));

    always @(posedge i_clock)
    begin
        if (dump_valid === 1'b1)
            dq.push_back(dump_data);
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_cmd(input rbq_cmd_t c, input rbq_buf_t b,
                          input int n, input logic [7:0] exp);
        int t;
        t = 0;
        do
        begin
            @(negedge i_clock);
            t++;
        end
        while (busy !== 1'b0 && t < 5000);
        rbq_host_model_inst.wa.delete();
        rbq_host_model_inst.wd.delete();
        dq.delete();
        @(posedge i_clock);
        cmd          <= c;
        cbuf         <= b;
        len          <= 16'(n);
        cmd_valid    <= 1'b1;
        status_clear <= 1'b1;
        start        <= (c == RBQ_CMD_SEND);
        @(posedge i_clock);
        cmd_valid    <= 1'b0;
        status_clear <= 1'b0;
        start        <= 1'b0;
        t = 0;
        do
        begin
            @(negedge i_clock);
            t++;
        end
        while (status[7] !== 1'b1 && t < 5000);
        repeat (2) @(negedge i_clock);
        chk("status", {24'h0, status}, {24'h0, exp});
    endtask

    task automatic check_frame(input int n, input int total, input int blk,
                               input logic [23:0] b0, b1, b2);
        logic [7:0]  e;
        logic [23:0] bases[3];
        int          k;
        bases = '{b0, b1, b2};
        chk("count", rbq_host_model_inst.wd.size(), total);
        for (int i = 0; i < rbq_host_model_inst.wd.size() && i < total; i++)
        begin
            k = i - 4;
            if (i < 2) e = 8'h00;
            else if (i < 4) e = 8'(total >> (8 * (i - 2)));
            else if (i < 10) e = 8'((i - 4) * 7 + 3);
            else if (i < 16) e = STATION[8 * (i - 10) +: 8];
            else if (i >= total - 4) e = FCS[8 * (i - total + 4) +: 8];
            else e = (k < n) ? 8'(k * 7 + 3) : 8'h00;
            chk("byte", rbq_host_model_inst.wd[i], e);
            chk("addr", rbq_host_model_inst.wa[i],
                bases[i / blk] + 24'(i % blk));
        end
    endtask

    task automatic t_formats();
        do_cmd(RBQ_CMD_SEND, '0, 56, RBQ_ST_CMD);
        chk("empty writes", rbq_host_model_inst.wd.size(), 0);
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_1000, 16'h0044}, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_2000, 16'h008E}, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_3000, 16'h008E}, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SEND, '0, 56, RBQ_ST_CMD | RBQ_ST_RCV);
        check_frame(56, 68, 4096, 24'h00_1000, 24'h0, 24'h0);
        slow <= 1'b1;
        do_cmd(RBQ_CMD_SEND, '0, 100, RBQ_ST_CMD | RBQ_ST_RCV);
        check_frame(100, 108, 4096, 24'h00_2000, 24'h0, 24'h0);
        slow <= 1'b0;
        do_cmd(RBQ_CMD_SEND, '0, 99, RBQ_ST_CMD | RBQ_ST_RCV);
        check_frame(99, 107, 4096, 24'h00_3000, 24'h0, 24'h0);
    endtask

    task automatic t_chain();
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_0400, 16'h0080}, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_0458, 16'h0080}, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_04B0, 16'h0080}, 0, RBQ_ST_CMD);
        slow <= 1'b1;
        do_cmd(RBQ_CMD_SEND, '0, 256, RBQ_ST_CMD | RBQ_ST_RCV);
        check_frame(256, 264, 128, 24'h00_0400, 24'h00_0458, 24'h00_04B0);
        slow <= 1'b0;
    endtask

    // a short non-octal buffer ends the frame; the buffer behind it must stay unused
    task automatic t_trunc_flush();
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_0800, 16'h0063}, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SUPPLY, '{24'h00_0C00, 16'h0080}, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SEND, '0, 99, RBQ_ST_CMD | RBQ_ST_RCV);
        chk("trunc count", rbq_host_model_inst.wd.size(), 99);
        chk("trunc end", rbq_host_model_inst.wa[98], 24'h00_0862);
        do_cmd(RBQ_CMD_FLUSH, '0, 0, RBQ_ST_CMD);
        do_cmd(RBQ_CMD_SEND, '0, 56, RBQ_ST_CMD);
        chk("flushed writes", rbq_host_model_inst.wd.size(), 0);
    endtask

    task automatic t_full_dump();
        rbq_buf_t    b;
        logic [39:0] w;
        for (int j = 0; j < 17; j++)
        begin
            b = '{24'h11_2233 + 24'(j) * 24'h01_0101, 16'h0040 + 16'(j * 8)};
            do_cmd(RBQ_CMD_SUPPLY, b, 0,
                   (j < 16) ? RBQ_ST_CMD : RBQ_ST_CMD | RBQ_ST_ERR);
        end
        do_cmd(RBQ_CMD_DUMP, '0, 0, RBQ_ST_CMD);
        chk("dump size", dq.size(), 80);
        for (int i = 0; i < 80 && i < dq.size(); i++)
        begin
            b = '{24'h11_2233 + 24'(i / 5) * 24'h01_0101,
                  16'h0040 + 16'((i / 5) * 8)};
            w = {b.count, b.addr};
            chk("dump byte", dq[i], w[8 * (i % 5) +: 8]);
        end
        do_cmd(RBQ_CMD_FLUSH, '0, 0, RBQ_ST_CMD);
    endtask

    task automatic t_reject();
        int lens[3] = '{0, 7, 1600};
        foreach (lens[i])
        begin
            do_cmd(RBQ_CMD_SEND, '0, lens[i], RBQ_ST_CMD | RBQ_ST_ERR);
            chk("reject writes", rbq_host_model_inst.wd.size(), 0);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // whole run is under two thousand cycles; 50k cycles means a hang
    initial
    begin
        #1_000_000;
        err_total++;
        finish_test();
    end

    initial
    begin
        repeat (8) @(posedge i_clock);
        i_srst <= 1'b0;
        t_formats();
        t_chain();
        t_trunc_flush();
        t_full_dump();
        t_reject();
        finish_test();
    end
endmodule // rbq_dma_tb
`default_nettype wire
